/* File: core/eve_core.sv */
// Exception vector selection, state save and cold reset initialisation.
//
// Contract
// - Cold reset, soft reset and NMI always go to the fixed reset vector.
// - Debug goes to low boot address, or alternative when probe enabled.
// - Ordinary vector is base plus offset; base chosen by boot vector bit.
// - Cache errors use offset 0x100 on an uncached base.
// - With exception level clear, refill offset 0x000, extended 0x080.
// - With exception level clear, interrupts use 0x200 if selected.
// - With exception level set, every ordinary exception but cache errors uses offset 0x180.
// - Level clear: save PC or PC minus four, set delay slot flag.
// - Level set: return address and delay slot flag stay unchanged.
// - Ordinary exceptions load exception code and coprocessor number.
// - After saving, set exception level and fetch from the vector.
// - Cold reset aborts everything and restarts from uncached space.
// - Cold reset loads replacement index with entry count minus one.
// - Cold reset clears the wired entry count.
// - Cold reset loads both configuration registers with boot state.
// - Cold reset sets boot vector and error level, clears four bits.
// - Cold reset clears watch enables and counter interrupt enables.
// - Cold reset saves PC, or PC minus four, as error return address.
// - Reset type exceptions win over every other pending exception.
`timescale 1ns/1ps
module eve_core #(
   parameter int TLB_ENTRIES = 16,
   parameter int WATCH_COUNT = 1,
   parameter int PERF_COUNT = 1
) (
   // Clock and cold reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB register port.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pipeline exception report and fetch redirect.
   input wire eve_pkg::eve_exc_t exc_in,
   output eve_pkg::eve_redirect_t redirect,
   // Mode bits seen by the rest of the core.
   output logic exception_level,
   output logic error_level,
   output logic boot_vector_select
);

   // Parameters the register layout cannot hold are refused.
   initial begin
      if (TLB_ENTRIES < 1 || TLB_ENTRIES > 64) begin
         $error("TLB_ENTRIES must lie in 1..64");
      end
      if (WATCH_COUNT < 1 || WATCH_COUNT > 8) begin
         $error("WATCH_COUNT must lie in 1..8");
      end
      if (PERF_COUNT < 1 || PERF_COUNT > 32) begin
         $error("PERF_COUNT must lie in 1..32");
      end
   end

   localparam logic [5:0] RANDOM_INIT = 6'(TLB_ENTRIES - 1);
   localparam int WB = WATCH_COUNT * eve_pkg::WATCH_BITS;

   logic reset_pending_q;
   logic [31:0] status_q;
   logic [31:0] cause_q;
   logic [63:0] exception_return_pc_q;
   logic [63:0] error_return_pc_q;
   logic [5:0] random_q;
   logic [5:0] wired_q;
   logic [31:0] config_q;
   logic [31:0] config_sec_q;
   logic probe_enable_q;
   logic [WB-1:0] watch_en_q;
   logic [PERF_COUNT-1:0] perf_ie_q;
   eve_pkg::eve_redirect_t redirect_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic take;
   logic ordinary;
   logic exc_lvl;
   logic wr;
   logic [63:0] restart_pc;

   // Return address of a faulting instruction, backing out a delay slot.
   function automatic logic [63:0] restart_of(input logic [63:0] pc,
                                              input logic in_slot);
      restart_of = in_slot ? pc - eve_pkg::SLOT_STEP : pc;
   endfunction

   // Vector address for one exception kind and the current mode bits.
   function automatic logic [63:0] vector_of(input eve_pkg::eve_kind_t k,
                                             input logic boot_sel,
                                             input logic lvl,
                                             input logic irq_sel,
                                             input logic probe);
      logic [63:0] ofs;
      ofs = eve_pkg::OFS_GENERAL;
      if (!lvl) begin
         if (k == eve_pkg::EK_REFILL) begin
            ofs = eve_pkg::OFS_REFILL;
         end else if (k == eve_pkg::EK_XREFILL) begin
            ofs = eve_pkg::OFS_XREFILL;
         end else if (k == eve_pkg::EK_IRQ && irq_sel) begin
            ofs = eve_pkg::OFS_IRQ;
         end
      end
      unique case (k)
         eve_pkg::EK_SOFT_RESET, eve_pkg::EK_NMI: begin
            vector_of = eve_pkg::RESET_VEC;
         end
         eve_pkg::EK_DEBUG: begin
            vector_of = probe ? eve_pkg::DBG_VEC_ALT
                              : eve_pkg::DBG_VEC_LO;
         end
         eve_pkg::EK_CACHE: begin
            vector_of = (boot_sel ? eve_pkg::BASE_BOOT : eve_pkg::BASE_UNC)
                        + eve_pkg::OFS_CACHE;
         end
         default: begin
            // Level set falls through with the general offset.
            vector_of = (boot_sel ? eve_pkg::BASE_BOOT : eve_pkg::BASE_KERN)
                        + ofs;
         end
      endcase
   endfunction

   // An exception is only taken once the reset entry has gone out, so a
   // report that overlaps the reset release is dropped.
   assign take = exc_in.valid && !reset_pending_q;
   assign ordinary = take && exc_in.kind != eve_pkg::EK_DEBUG
                     && exc_in.kind != eve_pkg::EK_SOFT_RESET
                     && exc_in.kind != eve_pkg::EK_NMI;
   assign exc_lvl = status_q[eve_pkg::S_XLVL];
   assign wr = psel && penable && pwrite;
   assign restart_pc = restart_of(exc_in.pc, exc_in.in_slot);

   // Outputs.
   assign redirect = redirect_q;
   assign exception_level = exc_lvl;
   assign error_level = status_q[eve_pkg::S_ELVL];
   assign boot_vector_select = status_q[eve_pkg::S_BOOT];
   assign prdata = prdata_q;
   assign pready = psel && penable;
   assign pslverr = pslverr_q && psel && penable;

   // The reset entry is sent on the first edge after release.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_pending_q <= 1'b1;
      end else begin
         reset_pending_q <= 1'b0;
      end
   end

   // Fetch redirect; cold reset always sends the fixed vector first.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         redirect_q <= '0;
      end else if (reset_pending_q) begin
         redirect_q.valid <= 1'b1;
         redirect_q.pc <= eve_pkg::RESET_VEC;
      end else if (take) begin
         redirect_q.valid <= 1'b1;
         redirect_q.pc <= vector_of(exc_in.kind,
                                    status_q[eve_pkg::S_BOOT], exc_lvl,
                                    cause_q[eve_pkg::C_IVSEL],
                                    probe_enable_q);
      end else begin
         redirect_q.valid <= 1'b0;
      end
   end

   // Status: reset state, software writes, exception level set on entry.
   // The hardware set wins over a software clear in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= '0;
         status_q[eve_pkg::S_BOOT] <= 1'b1;
         status_q[eve_pkg::S_ELVL] <= 1'b1;
      end else begin
         if (wr && paddr == eve_pkg::A_STATUS) begin
            status_q <= pwdata;
         end
         if (ordinary) begin
            status_q[eve_pkg::S_XLVL] <= 1'b1;
         end
      end
   end

   // Cause: delay slot flag, coprocessor and code; only the interrupt
   // vector select is writable by software.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_q <= '0;
      end else begin
         if (wr && paddr == eve_pkg::A_CAUSE) begin
            cause_q[eve_pkg::C_IVSEL] <= pwdata[eve_pkg::C_IVSEL];
         end
         if (ordinary) begin
            cause_q[eve_pkg::C_CODE_LSB +: 5] <= exc_in.code;
            cause_q[eve_pkg::C_CE_LSB +: 2] <= exc_in.cop;
            if (!exc_lvl) begin
               cause_q[eve_pkg::C_SLOT] <= exc_in.in_slot;
            end
         end
      end
   end

   // Exception return address; held while the level bit is set.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exception_return_pc_q <= '0;
      end else if (ordinary && !exc_lvl) begin
         exception_return_pc_q <= restart_pc;
      end else if (wr && paddr == eve_pkg::A_XRET_LO) begin
         exception_return_pc_q[31:0] <= pwdata;
      end else if (wr && paddr == eve_pkg::A_XRET_HI) begin
         exception_return_pc_q[63:32] <= pwdata;
      end
   end

   // Error return address. An asynchronous reset cannot sample the PC, so
   // it is caught at the first edge after release from the pipeline's
   // report port; after power-up that value is not meaningful.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         error_return_pc_q <= '0;
      end else if (reset_pending_q) begin
         error_return_pc_q <= restart_pc;
      end else if (wr && paddr == eve_pkg::A_ERR_LO) begin
         error_return_pc_q[31:0] <= pwdata;
      end else if (wr && paddr == eve_pkg::A_ERR_HI) begin
         error_return_pc_q[63:32] <= pwdata;
      end
   end

   // Translation replacement index and wired count.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         random_q <= RANDOM_INIT;
         wired_q <= '0;
      end else if (wr && paddr == eve_pkg::A_WIRED) begin
         wired_q <= pwdata[5:0];
      end
   end

   // Configuration; only the coherency field is writable.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_q <= eve_pkg::CONFIG_BOOT;
         config_sec_q <= eve_pkg::CONFIG_SEC_BOOT;
      end else if (wr && paddr == eve_pkg::A_CONFIG) begin
         config_q[2:0] <= pwdata[2:0];
      end
   end

   // Probe enable, watch enables and counter interrupt enables.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         probe_enable_q <= 1'b0;
         watch_en_q <= '0;
         perf_ie_q <= '0;
      end else begin
         if (wr && paddr == eve_pkg::A_PROBE) begin
            probe_enable_q <= pwdata[0];
         end
         if (wr && paddr == eve_pkg::A_WATCH) begin
            watch_en_q <= pwdata[WB-1:0];
         end
         if (wr && paddr == eve_pkg::A_PERF) begin
            perf_ie_q <= pwdata[PERF_COUNT-1:0];
         end
      end
   end

   // Read data is fetched in the setup cycle and shown in the access one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
         pslverr_q <= 1'b0;
      end else if (psel && !penable) begin
         pslverr_q <= 1'b0;
         unique case (paddr)
            eve_pkg::A_STATUS: prdata_q <= status_q;
            eve_pkg::A_CAUSE: prdata_q <= cause_q;
            eve_pkg::A_XRET_LO: prdata_q <= exception_return_pc_q[31:0];
            eve_pkg::A_XRET_HI: prdata_q <= exception_return_pc_q[63:32];
            eve_pkg::A_ERR_LO: prdata_q <= error_return_pc_q[31:0];
            eve_pkg::A_ERR_HI: prdata_q <= error_return_pc_q[63:32];
            eve_pkg::A_RANDOM: prdata_q <= {26'h0, random_q};
            eve_pkg::A_WIRED: prdata_q <= {26'h0, wired_q};
            eve_pkg::A_CONFIG: prdata_q <= config_q;
            eve_pkg::A_CONFIG_SEC: prdata_q <= config_sec_q;
            eve_pkg::A_PROBE: prdata_q <= {31'h0, probe_enable_q};
            eve_pkg::A_WATCH: prdata_q <= 32'(watch_en_q);
            eve_pkg::A_PERF: prdata_q <= 32'(perf_ie_q);
            default: begin
               prdata_q <= '0;
               pslverr_q <= 1'b1;
            end
         endcase
      end
   end

   AST_RESET_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
      reset_pending_q |=> redirect_q.valid
         && redirect_q.pc == eve_pkg::RESET_VEC)
      else $error("reset entry did not vector to the reset address");

   AST_RESET_STATE: assert property (@(posedge pclk) disable iff (!presetn)
      reset_pending_q |-> random_q == RANDOM_INIT && wired_q == 6'h00
         && status_q[eve_pkg::S_BOOT] && status_q[eve_pkg::S_ELVL]
         && !status_q[eve_pkg::S_TSHUT] && !status_q[eve_pkg::S_LOWPWR]
         && !status_q[eve_pkg::S_SRST] && !status_q[eve_pkg::S_NMI]
         && watch_en_q == '0 && perf_ie_q == '0
         && config_q[2:0] == eve_pkg::COHER_BOOT)
      else $error("cold reset state wrong");

   AST_DEBUG_VECTOR: assert property (@(posedge pclk) disable iff (!presetn)
      take && exc_in.kind == eve_pkg::EK_DEBUG |=> redirect_q.pc ==
         ($past(probe_enable_q) ? eve_pkg::DBG_VEC_ALT
                                : eve_pkg::DBG_VEC_LO))
      else $error("debug vector wrong");

   AST_CACHE_VECTOR: assert property (@(posedge pclk) disable iff (!presetn)
      take && exc_in.kind == eve_pkg::EK_CACHE |=> redirect_q.pc[15:0] ==
         ($past(status_q[eve_pkg::S_BOOT]) ? 16'h0300 : 16'h0100))
      else $error("cache error vector wrong");

   AST_REFILL_OFS: assert property (@(posedge pclk) disable iff (!presetn)
      take && !exc_lvl && !status_q[eve_pkg::S_BOOT]
         && exc_in.kind == eve_pkg::EK_XREFILL
      |=> redirect_q.pc == 64'hFFFF_FFFF_8000_0080)
      else $error("extended refill vector wrong");

   AST_IRQ_OFS: assert property (@(posedge pclk) disable iff (!presetn)
      take && !exc_lvl && status_q[eve_pkg::S_BOOT]
         && exc_in.kind == eve_pkg::EK_IRQ
      |=> redirect_q.pc[11:0] ==
         ($past(cause_q[eve_pkg::C_IVSEL]) ? 12'h400 : 12'h380))
      else $error("interrupt vector wrong");

   AST_LEVEL_OFS: assert property (@(posedge pclk) disable iff (!presetn)
      ordinary && exc_lvl && exc_in.kind != eve_pkg::EK_CACHE
      |=> redirect_q.pc[11:0] ==
         ($past(status_q[eve_pkg::S_BOOT]) ? 12'h380 : 12'h180))
      else $error("offset not general while level set");

   AST_SAVE_PC: assert property (@(posedge pclk) disable iff (!presetn)
      ordinary && !exc_lvl |=> exception_return_pc_q ==
         $past(restart_pc) && cause_q[eve_pkg::C_SLOT] ==
         $past(exc_in.in_slot))
      else $error("return address not saved");

   AST_HOLD_PC: assert property (@(posedge pclk) disable iff (!presetn)
      ordinary && exc_lvl && !wr |=> $stable(exception_return_pc_q)
         && $stable(cause_q[eve_pkg::C_SLOT]))
      else $error("return address changed while level set");

   // The redirect may only stay up a second cycle when a back to back
   // exception was taken in the cycle after this one.
   AST_CAUSE_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
      ordinary |=> (cause_q[eve_pkg::C_CODE_LSB +: 5] == $past(exc_in.code)
         && exc_lvl && redirect_q.valid)
         ##1 (!redirect_q.valid || $past(take)))
      else $error("cause or level not loaded on entry");

endmodule

/* File: core/eve_pkg.sv */
// Shared constants, types and register map of the exception entry block.
package eve_pkg;
   // Vector bases and fixed entry points.
   localparam logic [63:0] RESET_VEC = 64'hFFFF_FFFF_BFC0_0000;
   localparam logic [63:0] DBG_VEC_LO = 64'hFFFF_FFFF_BFC0_0480;
   localparam logic [63:0] DBG_VEC_ALT = 64'hFFFF_FFFF_FF20_0200;
   localparam logic [63:0] BASE_KERN = 64'hFFFF_FFFF_8000_0000;
   localparam logic [63:0] BASE_UNC = 64'hFFFF_FFFF_A000_0000;
   localparam logic [63:0] BASE_BOOT = 64'hFFFF_FFFF_BFC0_0200;
   // Vector offsets.
   localparam logic [63:0] OFS_REFILL = 64'h0000_0000_0000_0000;
   localparam logic [63:0] OFS_XREFILL = 64'h0000_0000_0000_0080;
   localparam logic [63:0] OFS_CACHE = 64'h0000_0000_0000_0100;
   localparam logic [63:0] OFS_GENERAL = 64'h0000_0000_0000_0180;
   localparam logic [63:0] OFS_IRQ = 64'h0000_0000_0000_0200;
   localparam logic [63:0] SLOT_STEP = 64'h0000_0000_0000_0004;
   // Register byte addresses.
   localparam logic [7:0] A_STATUS = 8'h00;
   localparam logic [7:0] A_CAUSE = 8'h04;
   localparam logic [7:0] A_XRET_LO = 8'h08;
   localparam logic [7:0] A_XRET_HI = 8'h0C;
   localparam logic [7:0] A_ERR_LO = 8'h10;
   localparam logic [7:0] A_ERR_HI = 8'h14;
   localparam logic [7:0] A_RANDOM = 8'h18;
   localparam logic [7:0] A_WIRED = 8'h1C;
   localparam logic [7:0] A_CONFIG = 8'h20;
   localparam logic [7:0] A_CONFIG_SEC = 8'h24;
   localparam logic [7:0] A_PROBE = 8'h28;
   localparam logic [7:0] A_WATCH = 8'h2C;
   localparam logic [7:0] A_PERF = 8'h30;
   // Status field positions.
   localparam int S_XLVL = 1;
   localparam int S_ELVL = 2;
   localparam int S_NMI = 19;
   localparam int S_SRST = 20;
   localparam int S_TSHUT = 21;
   localparam int S_BOOT = 22;
   localparam int S_LOWPWR = 27;
   // Cause field positions.
   localparam int C_CODE_LSB = 2;
   localparam int C_IVSEL = 23;
   localparam int C_CE_LSB = 28;
   localparam int C_SLOT = 31;
   // Configuration boot state; coherency field in bits 2:0.
   localparam logic [31:0] CONFIG_BOOT = 32'h0000_0002;
   localparam logic [31:0] CONFIG_SEC_BOOT = 32'h0000_0000;
   localparam logic [2:0] COHER_BOOT = 3'h2;
   // Watch enables per register: bit 2 instr, bit 1 read, bit 0 write.
   localparam int WATCH_BITS = 3;

   // Exception kinds as presented by the pipeline.
   typedef enum logic [2:0] {
      EK_GENERAL = 3'b000,
      EK_REFILL = 3'b001,
      EK_XREFILL = 3'b010,
      EK_IRQ = 3'b011,
      EK_CACHE = 3'b100,
      EK_DEBUG = 3'b101,
      EK_SOFT_RESET = 3'b110,
      EK_NMI = 3'b111
   } eve_kind_t;

   // One prioritised exception report from the pipeline.
   typedef struct packed {
      logic valid;
      eve_kind_t kind;
      logic [4:0] code;
      logic [1:0] cop;
      logic [63:0] pc;
      logic in_slot;
   } eve_exc_t;

   // Fetch redirect toward the pipeline.
   typedef struct packed {
      logic valid;
      logic [63:0] pc;
   } eve_redirect_t;
endpackage

/* File: sim/eve_pipe_model.sv */
// Behavioural pipeline that reports one prioritised exception at a time.
`timescale 1ns/1ps
module eve_pipe_model (
   // Clock.
   input wire logic pclk,
   // Exception report toward the block.
   output eve_pkg::eve_exc_t exc_out
);
   // Current fetch state; the block samples it at the reset restart edge.
   logic [63:0] cur_pc = 64'h0000_0000_0000_1000;
   logic cur_slot = 1'b0;
   logic [9:0] junk = 10'h000;
   eve_pkg::eve_exc_t rep = '0;

   // Idle qualifiers churn every cycle so a stale value is never trusted.
   always @(posedge pclk) begin
      junk <= junk + 10'h0B5;
   end

   // Outside a report only the program counter and the slot flag carry meaning.
   assign exc_out = rep.valid ? rep : {1'b0, junk, cur_pc, cur_slot};

   // One report per call; keep leaves it up so the next follows back to back.
   task automatic report(input eve_pkg::eve_kind_t k, input logic [4:0] c,
      input logic [1:0] cp, input logic [63:0] p, input logic s,
      input logic keep);
      @(posedge pclk);
      rep <= '{1'b1, k, c, cp, p, s};
      if (!keep) begin
         @(posedge pclk);
         rep <= '0;
      end
   endtask
endmodule

/* File: sim/testbench.sv */
// Self-checking bench for exception vectoring, state save and cold reset.
`timescale 1ns/1ps
module testbench;
   // One vector case: mode bits {bev, exl, iv, probe}, kind, low vector.
   typedef struct packed {
      logic [3:0] m;
      logic [2:0] k;
      logic [31:0] v;
   } eve_row_t;

   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic xlvl_o, elvl_o, boot_o, e, s, b, slot_last, ord;
   logic [4:0] c;
   logic [63:0] p;
   eve_pkg::eve_exc_t exc;
   eve_pkg::eve_redirect_t redir;
   int err_total = 0;
   int comparisons = 0;
   int cycles = 0;
   eve_row_t rows [17] = '{
      '{4'hF, 3'h6, 32'hBFC0_0000}, '{4'h0, 3'h7, 32'hBFC0_0000},
      '{4'hE, 3'h5, 32'hBFC0_0480}, '{4'h1, 3'h5, 32'hFF20_0200},
      '{4'h0, 3'h1, 32'h8000_0000}, '{4'h0, 3'h2, 32'h8000_0080},
      '{4'h4, 3'h1, 32'h8000_0180}, '{4'h8, 3'h1, 32'hBFC0_0200},
      '{4'h8, 3'h2, 32'hBFC0_0280}, '{4'hC, 3'h2, 32'hBFC0_0380},
      '{4'h0, 3'h4, 32'hA000_0100}, '{4'hC, 3'h4, 32'hBFC0_0300},
      '{4'h0, 3'h3, 32'h8000_0180}, '{4'h2, 3'h3, 32'h8000_0200},
      '{4'hA, 3'h3, 32'hBFC0_0400}, '{4'h6, 3'h3, 32'h8000_0180},
      '{4'h8, 3'h0, 32'hBFC0_0380}};

   // Design under test with a small translation table.
   eve_core #(.TLB_ENTRIES(8)) uut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .exc_in(exc), .redirect(redir),
      .exception_level(xlvl_o), .error_level(elvl_o),
      .boot_vector_select(boot_o));

   // Pipeline partner.
   eve_pipe_model pipe (.pclk(pclk), .exc_out(exc));

   // Core clock at 10 MHz.
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // A hang counts as a mismatch and closes the run.
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         err_total++;
         give_verdict();
      end
   end

   task give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic check(input string n, input logic [63:0] sn,
      input logic [63:0] ex);
      comparisons++;
      if (sn !== ex) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", n, ex, sn);
      end
   endtask

   // APB transfer; request held until pready is seen high at an edge.
   task automatic apb(input logic [7:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Only the bench timeout may end this wait.
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d, q, e);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] ex, input string n);
      apb(a, 1'b0, 32'h0000_0000, q, e);
      check(n, 64'(q & m), 64'(ex));
   endtask

   // Redirect pulses one cycle after the taking edge; bounded look.
   task automatic wait_redir();
      int n = 0;
      #1;
      while (redir.valid !== 1'b1 && n < 4) begin
         @(posedge pclk);
         #1;
         n++;
      end
   endtask

   // Cold reset for 16 cycles, then the boot state is read back.
   task automatic do_reset(input logic sl);
      @(posedge pclk);
      presetn <= 1'b0;
      pipe.cur_slot <= sl;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      wait_redir();
      check("reset redirect", 64'(redir.valid), 64'h1);
      check("reset vector", redir.pc, eve_pkg::RESET_VEC);
      check("boot select", 64'(boot_o), 64'h1);
      check("error level", 64'(elvl_o), 64'h1);
      check("exc level", 64'(xlvl_o), 64'h0);
      rd_chk(eve_pkg::A_STATUS, 32'h0878_0006, 32'h0040_0004, "st");
      rd_chk(eve_pkg::A_RANDOM, 32'hFFFF_FFFF, 32'h0000_0007, "rnd");
      rd_chk(eve_pkg::A_WIRED, 32'hFFFF_FFFF, 32'h0000_0000, "wired");
      rd_chk(eve_pkg::A_CONFIG, 32'h0000_0007, 32'h0000_0002, "k0");
      rd_chk(eve_pkg::A_CONFIG_SEC, 32'hFFFF_FFFF,
         eve_pkg::CONFIG_SEC_BOOT, "c1");
      rd_chk(eve_pkg::A_WATCH, 32'hFFFF_FFFF, 32'h0000_0000, "watch");
      rd_chk(eve_pkg::A_PERF, 32'hFFFF_FFFF, 32'h0000_0000, "perf");
      rd_chk(eve_pkg::A_ERR_LO, 32'hFFFF_FFFF, sl ? 32'hFFC : 32'h1000, "err");
   endtask

   // Main sequence: reset, vector table, awkward cases, second reset.
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      slot_last = 1'b0;
      do_reset(1'b0);
      for (int i = 0; i < 17; i++) begin
         c = 5'(i);
         s = c[0];
         p = 64'h0000_0001_0000_1000 + 64'(i * 16);
         ord = rows[i].k <= 3'h4;
         wr(eve_pkg::A_STATUS, (32'(rows[i].m[3]) << eve_pkg::S_BOOT) |
            (32'(rows[i].m[2]) << eve_pkg::S_XLVL));
         wr(eve_pkg::A_CAUSE, 32'(rows[i].m[1]) << eve_pkg::C_IVSEL);
         wr(eve_pkg::A_PROBE, 32'(rows[i].m[0]));
         wr(eve_pkg::A_XRET_LO, 32'h0000_5550);
         pipe.report(eve_pkg::eve_kind_t'(rows[i].k), c, c[1:0], p, s, 1'b0);
         wait_redir();
         check("vector", redir.pc, {32'hFFFF_FFFF, rows[i].v});
         check("redir", 64'(redir.valid), 64'h1);
         check("level", 64'(xlvl_o), 64'(ord | rows[i].m[2]));
         rd_chk(eve_pkg::A_XRET_LO, 32'hFFFF_FFFF, (ord & ~rows[i].m[2]) ?
            p[31:0] - (s ? 32'h4 : 32'h0) : 32'h5550, "epc");
         if (ord) begin
            if (!rows[i].m[2]) slot_last = s;
            b = slot_last;
            rd_chk(eve_pkg::A_CAUSE, 32'hB000_007C,
               (32'(b) << eve_pkg::C_SLOT) | (32'(c[1:0]) << eve_pkg::C_CE_LSB)
               | (32'(c) << eve_pkg::C_CODE_LSB), "cause");
         end
      end
      // Unmapped access is refused with an error and zero data.
      apb(8'hFC, 1'b0, 32'h0000_0000, q, e);
      check("slverr", 64'(e), 64'h1);
      check("unmapped data", 64'(q), 64'h0);
      wr(eve_pkg::A_CONFIG_SEC, 32'hFFFF_FFFF);
      rd_chk(eve_pkg::A_CONFIG_SEC, 32'hFFFF_FFFF,
         eve_pkg::CONFIG_SEC_BOOT, "c1 ro");
      // Back to back: the second sees the level already set.
      wr(eve_pkg::A_STATUS, 32'h0000_0000);
      pipe.report(eve_pkg::EK_GENERAL, 5'h0C, 2'h0, 64'h3000, 1'b0, 1'b1);
      pipe.report(eve_pkg::EK_REFILL, 5'h02, 2'h0, 64'h4000, 1'b1, 1'b0);
      wait_redir();
      check("b2b vector", redir.pc, 64'hFFFF_FFFF_8000_0180);
      rd_chk(eve_pkg::A_XRET_LO, 32'hFFFF_FFFF, 32'h3000,
         "b2b epc");
      rd_chk(eve_pkg::A_CAUSE, 32'hB000_007C, 32'h0000_0008, "b2b cause");
      // Disturb boot state, then a second cold reset in mid-run.
      wr(eve_pkg::A_WIRED, 32'h0000_0003);
      wr(eve_pkg::A_WATCH, 32'h0000_0007);
      wr(eve_pkg::A_PERF, 32'h0000_0001);
      wr(eve_pkg::A_CONFIG, 32'h0000_0005);
      wr(eve_pkg::A_STATUS, 32'h0838_0002);
      do_reset(1'b1);
      give_verdict();
   end
endmodule
